//--- hw/multipurpose_pin_function_select.sv
// top: four multipurpose pins, their role registers and control decode
// Notes on behaviour
// - pin 1 low five bits pick role
// - pin 1 code 10010 drives pulse density stream
// - pin 1 register resets to volume up
// - bank switch, compression, dsp bypass codes
// - codes 10000/10001 volume up/down buttons
// - pin 2 code zero is bit clock
// - pin 2 register resets to zero
// - pin 3 code zero is frame clock
// - pin 3 register resets to zero
// - pin 4 register resets to zero
// - pin 4 code zero is mic input
`default_nettype none
module multipurpose_pin_function_select (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  input wire pin_function_pkg::core_out_s core_out,
  output pin_function_pkg::core_in_s core_in,
  output pin_function_pkg::control_s control
);
  logic [7:0] cfg [pin_function_pkg::PINS];
  logic [4:0] code [pin_function_pkg::PINS];
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] level;
  logic [3:0] is_ctrl;
  logic [3:0] next_pin_out;
  logic [3:0] next_pin_oe_n;
  logic [7:0] next_rdata;
  pin_function_pkg::control_s next_control;
  pin_function_pkg::core_in_s next_core_in;
  int unsigned idx;

  always_comb begin
    idx = 0;
    case (reg_addr)
      pin_function_pkg::PIN1_OFFSET: idx = 0;
      pin_function_pkg::PIN2_OFFSET: idx = 1;
      pin_function_pkg::PIN3_OFFSET: idx = 2;
      pin_function_pkg::PIN4_OFFSET: idx = 3;
      default: idx = pin_function_pkg::PINS;
    endcase
  end

  // registers keep all eight bits so software reads back what it wrote
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg[0] <= pin_function_pkg::PIN1_RESET;
      cfg[1] <= pin_function_pkg::PIN2_RESET;
      cfg[2] <= pin_function_pkg::PIN3_RESET;
      cfg[3] <= pin_function_pkg::PIN4_RESET;
    end else if (reg_write && idx < pin_function_pkg::PINS) begin
      cfg[idx[1:0]] <= reg_wdata;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_read && idx < pin_function_pkg::PINS) begin
      next_rdata = cfg[idx[1:0]];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // upper bits ignored: a stray reserved bit cannot change the role
  always_comb begin
    for (int i = 0; i < pin_function_pkg::PINS; i++) begin
      code[i] = cfg[i][4:0] & pin_function_pkg::RESERVED_MASK[4:0];
    end
  end

  // three stages; change taken once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
      level <= 4'h0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 4; i++) begin
        if (sync2[i] == sync3[i]) begin
          level[i] <= sync3[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      is_ctrl[i] = code[i] >= pin_function_pkg::CODE_MUTE_IN0 &&
                   code[i] <= pin_function_pkg::CODE_VOL_DOWN &&
                   code[i] != pin_function_pkg::CODE_RSVD_C &&
                   code[i] != pin_function_pkg::CODE_RSVD_D;
    end
  end

  // pad drive; unknown codes leave the pin undriven
  always_comb begin
    next_pin_out = 4'h0;
    next_pin_oe_n = 4'hF;
    if (code[0] == pin_function_pkg::CODE_PRIMARY) begin
      next_pin_out[0] = core_out.serial_out_line_0;
      next_pin_oe_n[0] = 1'b0;
    end else if (code[0] == pin_function_pkg::CODE_PDM_OUT) begin
      next_pin_out[0] = core_out.pulse_density_out;
      next_pin_oe_n[0] = 1'b0;
    end
    if (code[1] == pin_function_pkg::CODE_PRIMARY) begin
      next_pin_out[1] = core_out.bit_clock_out;
      next_pin_oe_n[1] = ~core_out.bit_clock_drive;
    end
    if (code[2] == pin_function_pkg::CODE_PRIMARY) begin
      next_pin_out[2] = core_out.frame_clock_out;
      next_pin_oe_n[2] = ~core_out.frame_clock_drive;
    end
    for (int i = 0; i < 4; i++) begin
      if (is_ctrl[i]) begin
        next_pin_oe_n[i] = 1'b1;
        next_pin_out[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_out <= 4'h0;
      pin_oe_n <= 4'hF;
    end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // clock pins whatever their drive flag, and mic input, only in their primary role
  always_comb begin
    next_core_in = '0;
    if (code[1] == pin_function_pkg::CODE_PRIMARY) begin
      next_core_in.bit_clock_in = level[1];
    end
    if (code[2] == pin_function_pkg::CODE_PRIMARY) begin
      next_core_in.frame_clock_in = level[2];
    end
    if (code[3] == pin_function_pkg::CODE_PRIMARY) begin
      next_core_in.mic_data_in_01 = level[3];
    end
  end

  // several pins may share a control; their levels are or-ed
  always_comb begin
    next_control = '0;
    for (int i = 0; i < 4; i++) begin
      if (level[i]) begin
        case (code[i])
          pin_function_pkg::CODE_MUTE_IN0:
            next_control.mute_input[0] = 1'b1;
          pin_function_pkg::CODE_MUTE_IN1:
            next_control.mute_input[1] = 1'b1;
          pin_function_pkg::CODE_MUTE_IN2:
            next_control.mute_input[2] = 1'b1;
          pin_function_pkg::CODE_MUTE_IN3:
            next_control.mute_input[3] = 1'b1;
          pin_function_pkg::CODE_MUTE_IN01:
            next_control.mute_input[1:0] = 2'h3;
          pin_function_pkg::CODE_MUTE_IN23:
            next_control.mute_input[3:2] = 2'h3;
          pin_function_pkg::CODE_MUTE_INALL:
            next_control.mute_input = 4'hF;
          pin_function_pkg::CODE_MUTE_OUT0:
            next_control.mute_output[0] = 1'b1;
          pin_function_pkg::CODE_MUTE_OUT1:
            next_control.mute_output[1] = 1'b1;
          pin_function_pkg::CODE_MUTE_OUTALL:
            next_control.mute_output = 2'h3;
          pin_function_pkg::CODE_BANK_AB:
            next_control.bank_b = 1'b1;
          pin_function_pkg::CODE_COMPRESS:
            next_control.compress_en = 1'b1;
          pin_function_pkg::CODE_DSP_BYPASS:
            next_control.dsp_bypass = 1'b1;
          pin_function_pkg::CODE_VOL_UP:
            next_control.vol_up = 1'b1;
          pin_function_pkg::CODE_VOL_DOWN:
            next_control.vol_down = 1'b1;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control <= '0;
      core_in <= '0;
    end else begin
      control <= next_control;
      core_in <= next_core_in;
    end
  end

  property p_pin1_reset;
    @(posedge sys_clk) $fell(rst) |->
      cfg[0] == pin_function_pkg::PIN1_RESET;
  endproperty
  a_pin1_reset: assert property (p_pin1_reset)
    else $error("pin 1 reset value wrong");

  property p_resets_zero;
    @(posedge sys_clk) $fell(rst) |->
      cfg[1] == pin_function_pkg::PIN2_RESET &&
      cfg[2] == pin_function_pkg::PIN3_RESET &&
      cfg[3] == pin_function_pkg::PIN4_RESET;
  endproperty
  a_resets_zero: assert property (p_resets_zero)
    else $error("pins 2 to 4 reset value wrong");

  property p_pdm_drive;
    @(posedge sys_clk) disable iff (rst)
      code[0] == pin_function_pkg::CODE_PDM_OUT |=> !pin_oe_n[0] &&
        pin_out[0] == $past(core_out.pulse_density_out);
  endproperty
  a_pdm_drive: assert property (p_pdm_drive)
    else $error("pdm stream not on pin 1");

  property p_serial_drive;
    @(posedge sys_clk) disable iff (rst)
      code[0] == pin_function_pkg::CODE_PRIMARY |=> !pin_oe_n[0] &&
        pin_out[0] == $past(core_out.serial_out_line_0);
  endproperty
  a_serial_drive: assert property (p_serial_drive)
    else $error("serial output not on pin 1");

  property p_ctrl_input;
    @(posedge sys_clk) disable iff (rst)
      code[1] == pin_function_pkg::CODE_VOL_UP |=> pin_oe_n[1];
  endproperty
  a_ctrl_input: assert property (p_ctrl_input)
    else $error("control pin driven");

  property p_vol_up;
    @(posedge sys_clk) disable iff (rst)
      code[0] == pin_function_pkg::CODE_VOL_UP && level[0] |=>
        control.vol_up;
  endproperty
  a_vol_up: assert property (p_vol_up)
    else $error("volume up not raised");

  property p_mute_all;
    @(posedge sys_clk) disable iff (rst)
      code[2] == pin_function_pkg::CODE_MUTE_INALL && level[2] |=>
        control.mute_input == 4'hF;
  endproperty
  a_mute_all: assert property (p_mute_all)
    else $error("mute all inputs missing");

  property p_mute_out;
    @(posedge sys_clk) disable iff (rst)
      code[3] == pin_function_pkg::CODE_MUTE_OUTALL && level[3] |=>
        control.mute_output == 2'h3;
  endproperty
  a_mute_out: assert property (p_mute_out)
    else $error("mute both outputs missing");

  property p_bypass;
    @(posedge sys_clk) disable iff (rst)
      code[1] == pin_function_pkg::CODE_DSP_BYPASS && level[1] |=>
        control.dsp_bypass;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("dsp bypass missing");

  property p_mic;
    @(posedge sys_clk) disable iff (rst)
      code[3] == pin_function_pkg::CODE_PRIMARY |=>
        core_in.mic_data_in_01 == $past(level[3]);
  endproperty
  a_mic: assert property (p_mic)
    else $error("mic data not forwarded");

  property p_frame;
    @(posedge sys_clk) disable iff (rst)
      code[2] == pin_function_pkg::CODE_PRIMARY |=>
        core_in.frame_clock_in == $past(level[2]);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame clock not forwarded");

  // clock pads follow the serial port's own drive flag, not the code alone
  property p_bit_clock_drive;
    @(posedge sys_clk) disable iff (rst)
      code[1] == pin_function_pkg::CODE_PRIMARY |=>
        pin_oe_n[1] != $past(core_out.bit_clock_drive) &&
        pin_out[1] == $past(core_out.bit_clock_out);
  endproperty
  a_bit_clock_drive: assert property (p_bit_clock_drive)
    else $error("bit clock pad wrong");

  property p_frame_drive;
    @(posedge sys_clk) disable iff (rst)
      code[2] == pin_function_pkg::CODE_PRIMARY |=>
        pin_oe_n[2] != $past(core_out.frame_clock_drive) &&
        pin_out[2] == $past(core_out.frame_clock_out);
  endproperty
  a_frame_drive: assert property (p_frame_drive)
    else $error("frame clock pad wrong");

  property p_bit_clock_in;
    @(posedge sys_clk) disable iff (rst)
      code[1] == pin_function_pkg::CODE_PRIMARY |=>
        core_in.bit_clock_in == $past(level[1]);
  endproperty
  a_bit_clock_in: assert property (p_bit_clock_in)
    else $error("bit clock not forwarded");

  property p_reserved_released;
    @(posedge sys_clk) disable iff (rst)
      code[1] == pin_function_pkg::CODE_RSVD_C ||
        code[1] == pin_function_pkg::CODE_RSVD_D |=> pin_oe_n[1];
  endproperty
  a_reserved_released: assert property (p_reserved_released)
    else $error("reserved code drives pin 2");

  property p_mute_in0;
    @(posedge sys_clk) disable iff (rst)
      code[3] == pin_function_pkg::CODE_MUTE_IN0 && level[3] |=>
        control.mute_input[0];
  endproperty
  a_mute_in0: assert property (p_mute_in0)
    else $error("mute input 0 missing");

  property p_compress;
    @(posedge sys_clk) disable iff (rst)
      code[3] == pin_function_pkg::CODE_COMPRESS && level[3] |=>
        control.compress_en;
  endproperty
  a_compress: assert property (p_compress)
    else $error("compression enable missing");

  property p_bank;
    @(posedge sys_clk) disable iff (rst)
      code[3] == pin_function_pkg::CODE_BANK_AB && level[3] |=>
        control.bank_b;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank switch missing");

  property p_vol_down;
    @(posedge sys_clk) disable iff (rst)
      code[3] == pin_function_pkg::CODE_VOL_DOWN && level[3] |=>
        control.vol_down;
  endproperty
  a_vol_down: assert property (p_vol_down)
    else $error("volume down not raised");
endmodule
`default_nettype wire

//--- hw/pin_function_pkg.sv
// package: register map, role codes and carriers for the pin function select
`default_nettype none
package pin_function_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 5;
  localparam int PINS = 4;
  localparam logic [7:0] PIN1_OFFSET = 8'h39;
  localparam logic [7:0] PIN2_OFFSET = 8'h3A;
  localparam logic [7:0] PIN3_OFFSET = 8'h3B;
  localparam logic [7:0] PIN4_OFFSET = 8'h3C;
  localparam logic [7:0] PIN1_RESET = 8'h10;
  localparam logic [7:0] PIN2_RESET = 8'h00;
  localparam logic [7:0] PIN3_RESET = 8'h00;
  localparam logic [7:0] PIN4_RESET = 8'h00;
  localparam logic [7:0] RESERVED_MASK = 8'h1F;
  localparam logic [4:0] CODE_PRIMARY = 5'h00;
  localparam logic [4:0] CODE_MUTE_IN0 = 5'h01;
  localparam logic [4:0] CODE_MUTE_IN1 = 5'h02;
  localparam logic [4:0] CODE_MUTE_IN2 = 5'h03;
  localparam logic [4:0] CODE_MUTE_IN3 = 5'h04;
  localparam logic [4:0] CODE_MUTE_IN01 = 5'h05;
  localparam logic [4:0] CODE_MUTE_IN23 = 5'h06;
  localparam logic [4:0] CODE_MUTE_INALL = 5'h07;
  localparam logic [4:0] CODE_MUTE_OUT0 = 5'h08;
  localparam logic [4:0] CODE_MUTE_OUT1 = 5'h09;
  localparam logic [4:0] CODE_MUTE_OUTALL = 5'h0A;
  localparam logic [4:0] CODE_BANK_AB = 5'h0B;
  localparam logic [4:0] CODE_RSVD_C = 5'h0C;
  localparam logic [4:0] CODE_RSVD_D = 5'h0D;
  localparam logic [4:0] CODE_COMPRESS = 5'h0E;
  localparam logic [4:0] CODE_DSP_BYPASS = 5'h0F;
  localparam logic [4:0] CODE_VOL_UP = 5'h10;
  localparam logic [4:0] CODE_VOL_DOWN = 5'h11;
  localparam logic [4:0] CODE_PDM_OUT = 5'h12;

  // control requests gathered from all pins
  typedef struct packed {
    logic [3:0] mute_input;
    logic [1:0] mute_output;
    logic bank_b;
    logic compress_en;
    logic dsp_bypass;
    logic vol_up;
    logic vol_down;
  } control_s;

  // signals the serial port and pulse density logic offer to the pads
  typedef struct packed {
    logic serial_out_line_0;
    logic pulse_density_out;
    logic bit_clock_out;
    logic bit_clock_drive;
    logic frame_clock_out;
    logic frame_clock_drive;
  } core_out_s;

  typedef struct packed {
    logic bit_clock_in;
    logic frame_clock_in;
    logic mic_data_in_01;
  } core_in_s;
endpackage
`default_nettype wire

//--- testbench/pin_host.sv
// far-side model: buttons or serial host sharing the four pads
`default_nettype none
module pin_host (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] level,
  output logic [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // far side drives only pads the block has released, so no fight
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe_n[i] ? level[i] : pin_out[i];
    end
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the multipurpose pin function select
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // expected control word per role code, reserved and undefined give none
  localparam logic [10:0] CTL_TAB [0:18] = '{11'h000, 11'h080, 11'h100,
    11'h200, 11'h400, 11'h180, 11'h600, 11'h780, 11'h020, 11'h040,
    11'h060, 11'h010, 11'h000, 11'h000, 11'h008, 11'h004, 11'h002,
    11'h001, 11'h000};
  logic sys_clk, rst, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [3:0] pin_in, pin_out, pin_oe_n, level;
  pin_function_pkg::core_out_s core_out;
  pin_function_pkg::core_in_s core_in;
  pin_function_pkg::control_s control;
  int errors, checks_done;
  multipurpose_pin_function_select dut_u (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .core_out(core_out),
    .core_in(core_in), .control(control));
  pin_host host_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .level(level),
    .pin_in(pin_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // pad must be driven and carry the expected level three edges later
  task automatic drv(input int p, input logic [5:0] co, input logic e);
    @(posedge sys_clk) core_out <= co;
    wait_n(3);
    cmp({pin_oe_n[p], pin_out[p]}, {1'b0, e});
  endtask
  initial begin
    #500000;
    errors++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    level = 4'h0;
    core_out = '0;
    errors = 0;
    checks_done = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h39, d);
    cmp(d, 8'h10);
    rd(8'h3A, d);
    cmp(d, 8'h00);
    rd(8'h3B, d);
    cmp(d, 8'h00);
    rd(8'h3C, d);
    cmp(d, 8'h00);
    rd(8'h38, d);
    cmp(d, 8'h00);
    wait_n(1);
    cmp(reg_rdata, 8'h00);
    // pin 1 comes out of reset as the volume-up button
    @(posedge sys_clk) level <= 4'h1;
    wait_n(6);
    cmp(control, 11'h002);
    cmp(pin_oe_n[0], 1'b1);
    // codes 1 to 18 on pin 4 with its pad held high
    @(posedge sys_clk) level <= 4'h8;
    for (int c = 1; c < 19; c++) begin
      wr(8'h3C, 8'(c));
      rd(8'h3C, d);
      cmp(d, 8'(c));
      wait_n(6);
      cmp(control, CTL_TAB[c]);
      cmp(pin_oe_n[3], 1'b1);
    end
    wr(8'h3C, 8'h00);
    wait_n(6);
    cmp(core_in.mic_data_in_01, 1'b1);
    @(posedge sys_clk) level <= 4'h0;
    wait_n(6);
    cmp(core_in.mic_data_in_01, 1'b0);
    cmp(control, 11'h000);
    wr(8'h39, 8'h00);
    drv(0, 6'h20, 1'b1);
    drv(0, 6'h10, 1'b0);
    wr(8'h39, 8'h12);
    drv(0, 6'h10, 1'b1);
    drv(0, 6'h20, 1'b0);
    drv(1, 6'h0C, 1'b1);
    drv(1, 6'h04, 1'b0);
    drv(2, 6'h03, 1'b1);
    drv(2, 6'h01, 1'b0);
    // a clock slave forwards the pad level to the serial port
    @(posedge sys_clk) core_out <= '0;
    level <= 4'h6;
    wait_n(6);
    cmp({core_in.bit_clock_in, core_in.frame_clock_in}, 2'b11);
    // reserved codes leave the pads released and raise nothing
    wr(8'h3A, 8'h0C);
    wr(8'h3B, 8'h0D);
    @(posedge sys_clk) core_out <= 6'h0F;
    wait_n(6);
    cmp(pin_oe_n[2:1], 2'b11);
    cmp(control, 11'h000);
    wr(8'h3A, 8'h10);
    wr(8'h3B, 8'h07);
    wait_n(6);
    cmp(pin_oe_n[2:1], 2'b11);
    cmp(control, 11'h782);
    wr(8'h3A, 8'h0F);
    wait_n(6);
    cmp(control, 11'h784);
    close_out();
  end
endmodule
`default_nettype wire
